// ==== bench/gpio_pin1_output_mux_tb.sv ====
// Self-checking bench of the pin-1 output mux.
`timescale 1ns/100ps
`include "gpm_regs.svh"
module gpio_pin1_output_mux_tb;
   import gpm_pkg::*;
   // ============================================================
   // Signals
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [9:0] addr = 10'h000;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hf;
   logic [31:0] rdata;
   logic wait_r, p_out, p_oe, line;
   gpm_rx_t [3:0] rx = '0;
   gpm_tx_t [1:0] tx = '0;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   logic [7:0] expq[$];
   always #2 sys_clk = ~sys_clk;
   gpm_pin1_mux DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(addr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_byteenable(be), .avs_readdata(rdata),
      .avs_waitrequest(wait_r), .rx_status(rx), .tx_status(tx),
      .pin1_out(p_out), .pin1_oe(p_oe));
   gpm_pin_sampler far_end (.pin_out(p_out), .pin_oe(p_oe),
      .pin_line(line));
   // ============================================================
   // Tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("mismatches %0d comparisons %0d", err_total, checks);
      if (err_total == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
      addr <= a;
      wr <= w;
      rd <= ~w;
      wdata <= {24'h0, d};
      do @(posedge sys_clk); while (wait_r !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rd_chk(input logic [9:0] a, input logic [7:0] e);
      expq.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask
   function automatic logic exp_pin(input logic [7:0] c);
      gpm_ctl_t k;
      gpm_tx_t t;
      gpm_rx_t r;
      logic a, o;
      k = c;
      a = 1'b1;
      o = 1'b0;
      t = tx[k.pin1_source_select[0]];
      for (int j = 0; j < 4; j++) begin
         if (k.pin1_source_select == 3'h4 && rx[j].enabled) o |= rx[j].lock;
         if (k.pin1_source_select > 3'h5 && t.rx_member[j]) begin
            a &= rx[j].pass;
            o |= rx[j].pass;
         end
      end
      if (k.pin1_source_select < 3'h4) begin
         r = rx[k.pin1_source_select[1:0]];
         case (k.pin1_signal_select)
            3'h4: return r.lock;
            3'h5: return r.pass;
            3'h6: return r.frame_valid;
            3'h7: return r.line_valid;
            default: return r.remote_pin[k.pin1_signal_select[1:0]];
         endcase
      end
      if (k.pin1_source_select == 3'h4) begin
         if (k.pin1_signal_select < 3'h2)
            return k.pin1_signal_select[0] ? o : k.pin1_local_value;
         return 1'b0;
      end
      if (k.pin1_source_select == 3'h5) return 1'b0;
      case (k.pin1_signal_select)
         3'h0: return a;
         3'h1: return o;
         3'h2: return t.frame_active;
         3'h3: return t.line_active;
         3'h4: return t.synced;
         3'h5: return t.irq;
         default: return 1'b0;
      endcase
   endfunction
   // ============================================================
   // Watchers
   always @(posedge sys_clk) begin
      if (rd && !wait_r) begin
         chk(rdata, {24'h0, expq.pop_front()});
      end
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         wrap_up;
      end
   end
   // ============================================================
   // Sequence
   initial begin
      logic [7:0] v;
      void'($urandom(31));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd_chk(`GPM_CTL_ADDR, `GPM_CTL_RESET);
      bus(1'b1, `GPM_CTL_ADDR + 10'h004, 8'hff);
      rd_chk(`GPM_CTL_ADDR + 10'h004, 8'h00);
      be <= 4'he;
      bus(1'b1, `GPM_CTL_ADDR, 8'hff);
      be <= 4'hf;
      rd_chk(`GPM_CTL_ADDR, 8'h00);
      chk(p_oe, 1'b0);
      for (int i = 0; i < 64; i++) begin
         v = {i[5:0], 1'($urandom()), 1'b1};
         rx <= 36'({$urandom(), $urandom()});
         tx <= 16'($urandom());
         bus(1'b1, `GPM_CTL_ADDR, v);
         repeat (3) @(posedge sys_clk);
         chk(p_oe, 1'b1);
         chk(line, exp_pin(v));
         chk(p_out, exp_pin(v));
         rd_chk(`GPM_CTL_ADDR, v);
      end
      // A second reset in mid-run must clear a register that is in use.
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      chk(p_oe, 1'b0);
      rd_chk(`GPM_CTL_ADDR, `GPM_CTL_RESET);
      bus(1'b1, `GPM_CTL_ADDR, 8'h92);
      repeat (3) @(posedge sys_clk);
      chk(p_oe, 1'b0);
      wrap_up;
   end
endmodule

// ==== bench/gpm_pin_sampler.sv ====
// Model of the outside logic that samples general-purpose pin 1.
`timescale 1ns/100ps
module gpm_pin_sampler (
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_line
);
   logic last_ff = 1'b0;
   // A released line must not look like a stale drive, so it flips.
   always @(pin_out, pin_oe) if (pin_oe) last_ff = pin_out;
   assign pin_line = pin_oe ? pin_out : ~last_ff;
endmodule

// ==== verilog/gpm_pin1_mux.sv ====
// Pin-1 output control register with its source multiplexer.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/100ps
`include "gpm_regs.svh"

// Operation
// [R1] Control register sits at offset 0x11 and resets to zero.
// [R2] Source bits 4:2: receive ports 0-3, device status, reserved, transmit 0/1.
// [R3] Receive source, select 000 drives remote pin 0, 011 remote pin 3.
// [R4] Receive source, select 001 and 010 drive remote pins 1 and 2.
// [R5] Receive source, select 100 drives lock, 101 drives pass.
// [R6] Receive source, select 110 frame-valid, 111 line-valid.
// [R7] Device source, select 000 drives the local value bit.
// [R8] Device source, select 001 drives OR of enabled ports' lock.
// [R9] Transmit source, 000 AND and 001 OR of member ports' pass.
// [R10] Transmit source, 010 frame active, 011 line active.
// [R11] Transmit source, 100 synchronized, 101 transmit interrupt.
// [R12] Bit 1 holds a writable local value used as pin level.
// [R13] Pin driver enabled only while bit 0 is one.
module gpm_pin1_mux
   import gpm_pkg::*;
#(
   parameter int ADDR_W = 10
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire gpm_rx_t [3:0] rx_status,
   input wire gpm_tx_t [1:0] tx_status,
   output logic pin1_out,
   output logic pin1_oe
);

   // ============================================================
   // Register bus
   // One wait state: each request is answered one cycle after it arrives.
   gpm_ctl_t ctl_ff, nxt_ctl;
   logic ack_ff, nxt_ack;
   logic [31:0] rdata_ff, nxt_rdata;
   logic hit;

   always_comb begin
      hit = (avs_address == ADDR_W'(`GPM_CTL_ADDR)); // see [R1]
      nxt_ctl = ctl_ff;
      nxt_ack = (avs_read | avs_write) & ~ack_ff;
      nxt_rdata = rdata_ff;
      // A write lands only at the edge that sees waitrequest low, never
      // while the master is still being held off.
      if (ack_ff && avs_write && hit && avs_byteenable[0]) begin
         nxt_ctl = gpm_ctl_t'(avs_writedata[7:0]); // see [R12]
      end
      if (nxt_ack && avs_read) begin
         // Unmapped addresses read as zero and ignore writes.
         nxt_rdata = hit ? {24'h000000, ctl_ff} : 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctl_ff <= gpm_ctl_t'(`GPM_CTL_RESET); // see [R1]
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end else begin
         ctl_ff <= nxt_ctl;
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
   assign avs_readdata = rdata_ff;

   // ============================================================
   // Source multiplexer
   logic level_ff, nxt_level;
   logic oe_ff, nxt_oe;
   logic [3:0] pass_v;
   gpm_rx_t rx;
   gpm_tx_t tx;
   logic any_lock;

   always_comb begin
      rx = rx_status[ctl_ff.pin1_source_select[1:0]]; // see [R2]
      tx = tx_status[ctl_ff.pin1_source_select[0]];
      any_lock = 1'b0;
      for (int i = 0; i < 4; i++) begin
         pass_v[i] = rx_status[i].pass;
         any_lock = any_lock | (rx_status[i].lock & rx_status[i].enabled);
      end
      nxt_level = 1'b0;
      unique case (gpm_src_t'(ctl_ff.pin1_source_select))
         GPM_SRC_RX0, GPM_SRC_RX1, GPM_SRC_RX2, GPM_SRC_RX3: begin
            unique case (ctl_ff.pin1_signal_select)
               3'h0, 3'h1, 3'h2, 3'h3: begin
                  nxt_level = rx.remote_pin[ctl_ff.pin1_signal_select[1:0]];
               end // see [R3] see [R4]
               3'h4: nxt_level = rx.lock; // see [R5]
               3'h5: nxt_level = rx.pass; // see [R5]
               3'h6: nxt_level = rx.frame_valid; // see [R6]
               3'h7: nxt_level = rx.line_valid; // see [R6]
            endcase
         end
         GPM_SRC_DEV: begin
            if (ctl_ff.pin1_signal_select == 3'h0) begin
               nxt_level = ctl_ff.pin1_local_value; // see [R7] see [R12]
            end else if (ctl_ff.pin1_signal_select == 3'h1) begin
               nxt_level = any_lock; // see [R8]
            end
         end
         GPM_SRC_TX0, GPM_SRC_TX1: begin
            unique case (ctl_ff.pin1_signal_select)
               3'h0: nxt_level = &(pass_v | ~tx.rx_member); // see [R9]
               3'h1: nxt_level = |(pass_v & tx.rx_member); // see [R9]
               3'h2: nxt_level = tx.frame_active; // see [R10]
               3'h3: nxt_level = tx.line_active; // see [R10]
               3'h4: nxt_level = tx.synced; // see [R11]
               3'h5: nxt_level = tx.irq; // see [R11]
               default: nxt_level = 1'b0;
            endcase
         end
         // Reserved source drives low rather than floating.
         default: nxt_level = 1'b0;
      endcase
      nxt_oe = ctl_ff.pin1_drive_enable; // see [R13]
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         level_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else begin
         level_ff <= nxt_level;
         oe_ff <= nxt_oe;
      end
   end

   assign pin1_out = level_ff;
   assign pin1_oe = oe_ff;

   // ============================================================
   // Checks
   reset_value_a: assert property (@(posedge sys_clk) // see [R1]
      $past(rst) |-> ctl_ff == gpm_ctl_t'(8'h00))
      else $error("control register not cleared by reset");

   drive_enable_a: assert property (@(posedge sys_clk) // see [R13]
      disable iff (rst) pin1_oe == $past(ctl_ff.pin1_drive_enable))
      else $error("output enable does not follow bit 0");

   local_value_a: assert property (@(posedge sys_clk) // see [R7]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h4 && ctl_ff.pin1_signal_select == 3'h0)
      |=> pin1_out == $past(ctl_ff.pin1_local_value))
      else $error("local value not driven");

   rx_lock_a: assert property (@(posedge sys_clk) // see [R5]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h2 && ctl_ff.pin1_signal_select == 3'h4)
      |=> pin1_out == $past(rx_status[2].lock))
      else $error("receive lock not driven");

   rx_pin_a: assert property (@(posedge sys_clk) // see [R3]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h1 && ctl_ff.pin1_signal_select == 3'h3)
      |=> pin1_out == $past(rx_status[1].remote_pin[3]))
      else $error("remote pin 3 not driven");

   tx_sync_a: assert property (@(posedge sys_clk) // see [R11]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h7 && ctl_ff.pin1_signal_select == 3'h4)
      |=> pin1_out == $past(tx_status[1].synced))
      else $error("synchronized status not driven");

   reserved_low_a: assert property (@(posedge sys_clk) // see [R2]
      disable iff (rst)
      ctl_ff.pin1_source_select == 3'h5 |=> !pin1_out)
      else $error("reserved source not low");

   bus_answer_a: assert property (@(posedge sys_clk) // see [R12]
      disable iff (rst)
      (avs_write && !avs_waitrequest && hit && avs_byteenable[0])
      |=> ctl_ff == gpm_ctl_t'($past(avs_writedata[7:0])))
      else $error("register write lost");

   rx_pin0_a: assert property (@(posedge sys_clk) // see [R3]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h2 && ctl_ff.pin1_signal_select == 3'h0)
      |=> pin1_out == $past(rx_status[2].remote_pin[0]))
      else $error("remote pin 0 not driven");

   rx_pin1_a: assert property (@(posedge sys_clk) // see [R4]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h0 && ctl_ff.pin1_signal_select == 3'h1)
      |=> pin1_out == $past(rx_status[0].remote_pin[1]))
      else $error("remote pin 1 not driven");

   rx_pin2_a: assert property (@(posedge sys_clk) // see [R4]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h3 && ctl_ff.pin1_signal_select == 3'h2)
      |=> pin1_out == $past(rx_status[3].remote_pin[2]))
      else $error("remote pin 2 not driven");

   rx_pass_a: assert property (@(posedge sys_clk) // see [R5]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h1 && ctl_ff.pin1_signal_select == 3'h5)
      |=> pin1_out == $past(rx_status[1].pass))
      else $error("receive pass not driven");

   rx_frame_a: assert property (@(posedge sys_clk) // see [R6]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h3 && ctl_ff.pin1_signal_select == 3'h6)
      |=> pin1_out == $past(rx_status[3].frame_valid))
      else $error("receive frame-valid not driven");

   rx_line_a: assert property (@(posedge sys_clk) // see [R6]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h0 && ctl_ff.pin1_signal_select == 3'h7)
      |=> pin1_out == $past(rx_status[0].line_valid))
      else $error("receive line-valid not driven");

   dev_lock_a: assert property (@(posedge sys_clk) // see [R8]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h4 && ctl_ff.pin1_signal_select == 3'h1)
      |=> pin1_out == $past((rx_status[0].lock & rx_status[0].enabled)
         | (rx_status[1].lock & rx_status[1].enabled)
         | (rx_status[2].lock & rx_status[2].enabled)
         | (rx_status[3].lock & rx_status[3].enabled)))
      else $error("OR of enabled lock not driven");

   dev_reserved_a: assert property (@(posedge sys_clk) // see [R2]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h4 && ctl_ff.pin1_signal_select > 3'h1)
      |=> !pin1_out)
      else $error("unused device select not low");

   tx_and_a: assert property (@(posedge sys_clk) // see [R9]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h6 && ctl_ff.pin1_signal_select == 3'h0)
      |=> pin1_out == $past(&({rx_status[3].pass, rx_status[2].pass,
         rx_status[1].pass, rx_status[0].pass} | ~tx_status[0].rx_member)))
      else $error("AND of member pass not driven");

   tx_or_a: assert property (@(posedge sys_clk) // see [R9]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h7 && ctl_ff.pin1_signal_select == 3'h1)
      |=> pin1_out == $past(|({rx_status[3].pass, rx_status[2].pass,
         rx_status[1].pass, rx_status[0].pass} & tx_status[1].rx_member)))
      else $error("OR of member pass not driven");

   tx_frame_a: assert property (@(posedge sys_clk) // see [R10]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h6 && ctl_ff.pin1_signal_select == 3'h2)
      |=> pin1_out == $past(tx_status[0].frame_active))
      else $error("transmit frame activity not driven");

   tx_line_a: assert property (@(posedge sys_clk) // see [R10]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h7 && ctl_ff.pin1_signal_select == 3'h3)
      |=> pin1_out == $past(tx_status[1].line_active))
      else $error("transmit line activity not driven");

   tx_irq_a: assert property (@(posedge sys_clk) // see [R11]
      disable iff (rst)
      (ctl_ff.pin1_source_select == 3'h6 && ctl_ff.pin1_signal_select == 3'h5)
      |=> pin1_out == $past(tx_status[0].irq))
      else $error("transmit interrupt not driven");

   tx_reserved_a: assert property (@(posedge sys_clk) // see [R11]
      disable iff (rst)
      (ctl_ff.pin1_source_select > 3'h5 && ctl_ff.pin1_signal_select > 3'h5)
      |=> !pin1_out)
      else $error("unused transmit select not low");

   write_refused_a: assert property (@(posedge sys_clk) // see [R1]
      disable iff (rst)
      (avs_write && !avs_waitrequest && !(hit && avs_byteenable[0]))
      |=> $stable(ctl_ff))
      else $error("refused write changed the register");

   ctl_hold_a: assert property (@(posedge sys_clk) // see [R12]
      disable iff (rst)
      !(avs_write && !avs_waitrequest) |=> $stable(ctl_ff))
      else $error("register changed without an accepted write");

   read_back_a: assert property (@(posedge sys_clk) // see [R12]
      disable iff (rst)
      (avs_read && !avs_waitrequest && hit)
      |-> avs_readdata == {24'h000000, $past(ctl_ff)})
      else $error("read data does not match the register");

   read_unmapped_a: assert property (@(posedge sys_clk) // see [R1]
      disable iff (rst)
      (avs_read && !avs_waitrequest && !hit)
      |-> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");

   wait_once_a: assert property (@(posedge sys_clk) // see [R12]
      disable iff (rst)
      avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait state");

   wait_first_a: assert property (@(posedge sys_clk) // see [R12]
      disable iff (rst)
      ((avs_read || avs_write) && !$past(avs_read || avs_write))
      |-> avs_waitrequest)
      else $error("new request not held off one cycle");

   reset_outputs_a: assert property (@(posedge sys_clk) // see [R1]
      rst |=> (!pin1_oe && !pin1_out && avs_readdata == 32'h00000000))
      else $error("outputs not cleared by reset");
endmodule

// ==== verilog/gpm_pkg.sv ====
// Types shared by the pin-1 output mux.
package gpm_pkg;
   // ============================================================
   // Source and select codes
   typedef enum logic [2:0] {
      GPM_SRC_RX0 = 3'h0,
      GPM_SRC_RX1 = 3'h1,
      GPM_SRC_RX2 = 3'h2,
      GPM_SRC_RX3 = 3'h3,
      GPM_SRC_DEV = 3'h4,
      GPM_SRC_RSV = 3'h5,
      GPM_SRC_TX0 = 3'h6,
      GPM_SRC_TX1 = 3'h7
   } gpm_src_t;

   typedef struct packed {
      logic [2:0] pin1_signal_select;
      logic [2:0] pin1_source_select;
      logic pin1_local_value;
      logic pin1_drive_enable;
   } gpm_ctl_t;

   // Status of one receive port.
   typedef struct packed {
      logic [3:0] remote_pin;
      logic lock;
      logic pass;
      logic frame_valid;
      logic line_valid;
      logic enabled;
   } gpm_rx_t;

   // Status of one CSI-2 transmit port.
   typedef struct packed {
      logic [3:0] rx_member;
      logic frame_active;
      logic line_active;
      logic synced;
      logic irq;
   } gpm_tx_t;
endpackage

// ==== verilog/gpm_regs.svh ====
// Register offsets, field positions and reset values of the pin-1 output mux.
`ifndef GPM_REGS_SVH
`define GPM_REGS_SVH
// ============================================================
// Offsets and fields
`define GPM_CTL_INDEX 8'h11
`define GPM_CTL_ADDR 10'h044
`define GPM_CTL_RESET 8'h00
`define GPM_EN_BIT 0
`define GPM_VAL_BIT 1
`define GPM_SRC_LSB 2
`define GPM_SRC_MSB 4
`define GPM_SEL_LSB 5
`define GPM_SEL_MSB 7
`endif
